// File: ppf_map.svh
// Constants for the printer port frame forwarder
`ifndef PPF_MAP_SVH
`define PPF_MAP_SVH

// ----------------------------------------------------------------
// Host command codes
// ----------------------------------------------------------------
`define PPF_CMD_OPEN 3'h0
`define PPF_CMD_CLOSE 3'h1
`define PPF_CMD_WRITE 3'h2
`define PPF_CMD_STATUS 3'h3

// ----------------------------------------------------------------
// Characters and frame
// ----------------------------------------------------------------
`define PPF_LINE_END_CODE 8'h9b
`define PPF_CR_CODE 8'h0d
`define PPF_BLANK_CODE 8'h20
`define PPF_FRAME_LEN 6'h28
`define PPF_FRAME_LAST 6'h27

// ----------------------------------------------------------------
// Result codes
// ----------------------------------------------------------------
`define PPF_RES_OK 8'h80
`define PPF_RES_BAD_CMD 8'h81
`define PPF_RES_FRAME_ERR 8'h82
`define PPF_RES_TIMEOUT 8'h84

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PPF_CLK_MHZ 100
`define PPF_CLK_NS 10
`define PPF_TIMEOUT_MS 4000
`define PPF_TIMEOUT_CYC (`PPF_TIMEOUT_MS * 1000 * `PPF_CLK_MHZ)
`define PPF_STROBE_NS 1000
`define PPF_STROBE_CYC ((`PPF_STROBE_NS + `PPF_CLK_NS - 1) / `PPF_CLK_NS)

`endif

// File: ppf_pkg.sv
// Types for the printer port frame forwarder
package ppf_pkg;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } ppf_byte_t;

    typedef enum logic [1:0] {
        PPF_ST_IDLE,
        PPF_ST_FRAME,
        PPF_ST_DRAIN
    } ppf_state_t;

    typedef enum logic [1:0] {
        PPF_PR_IDLE,
        PPF_PR_STROBE,
        PPF_PR_WAIT
    } ppf_prn_state_t;

endpackage

// File: ppf_forwarder.sv
// Printer port frame forwarder: host frames in, printer characters out
`timescale 1ns/1ns
`include "ppf_map.svh"

// Contract
// - Printer commands are served only while a printer is detected.
// - Data arrives in 40-byte frames, forwarded one character at a time.
// - All characters of a frame acknowledged within 4 s, else timed out.
// - Characters after a line end code in a frame are discarded.
// - Line end code is sent to the printer as carriage return 13.
// - Other bytes pass unchanged, top bit kept, no line feed added.
// - Back-to-back line end codes print as alternating CR and blank.
// - A frame without line end code sends all 40 bytes.
// - Status query answered only with a printer present and powered.
// - Status reply gives result: 128 ok, 129, 130, 132 timeout.
module ppf_forwarder
    import ppf_pkg::*;
#(
    parameter logic [28:0] TIMEOUT_CYC = 29'(`PPF_TIMEOUT_CYC)
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    output logic cmd_ready,
    input wire logic in_valid,
    input wire ppf_byte_t in_byte,
    output logic in_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_code,
    input wire logic prn_present,
    input wire logic prn_power,
    input wire logic prn_busy,
    input wire logic prn_ack,
    output logic [7:0] prn_data,
    output logic prn_strobe
);

    localparam logic [6:0] STROBE_CYC = 7'(`PPF_STROBE_CYC);
    function automatic logic is_line_end(input logic [7:0] b);
        return b == `PPF_LINE_END_CODE;
    endfunction
    function automatic logic bump(input logic p);
        return ~p;
    endfunction
    ppf_state_t st_q;
    ppf_prn_state_t pst_q;
    logic [5:0] cnt_q;
    logic drop_q;
    logic ferr_q;
    logic tmo_q;
    logic eol_ph_q;
    logic [28:0] tmr_q;
    logic [7:0] res_q;
    logic ready_q;
    logic cmd_ready_q;
    logic rsp_valid_q;
    logic [7:0] rsp_code_q;
    logic [7:0] mem_q [2];
    logic wp_q;
    logic rp_q;
    logic [1:0] fcnt_q;
    logic [1:0] fcnt_d;
    logic [6:0] stb_q;
    logic [7:0] prn_data_q;
    logic prn_strobe_q;
    logic take_cmd;
    logic take_byte;
    logic frame_end;
    logic wr_en;
    logic [7:0] wr_data;
    logic rd_en;
    logic frame_done;
    logic tmo_hit;
    assign cmd_ready = cmd_ready_q;
    assign in_ready = ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_code = rsp_code_q;
    assign prn_data = prn_data_q;
    assign prn_strobe = prn_strobe_q;

    // ------------------------------------------------------------
    // Command and frame intake
    // ------------------------------------------------------------
    assign take_cmd = cmd_valid && cmd_ready_q;
    assign take_byte = in_valid && ready_q;
    assign frame_end = take_byte && (in_byte.last || cnt_q == `PPF_FRAME_LAST);
    assign tmo_hit = (st_q != PPF_ST_IDLE) && !tmo_q && (tmr_q >= TIMEOUT_CYC);
    assign frame_done = (st_q == PPF_ST_DRAIN) && fcnt_q == 2'd0 && pst_q == PPF_PR_IDLE;
    // Filter: truncation, translation, alternation
    always_comb begin
        wr_en = 1'b0;
        wr_data = in_byte.data;
        if (take_byte && !drop_q && !tmo_q) begin
            wr_en = 1'b1;
            if (is_line_end(in_byte.data)) begin
                wr_data = eol_ph_q ? `PPF_BLANK_CODE : `PPF_CR_CODE;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= PPF_ST_IDLE;
        end else begin
            case (st_q)
                PPF_ST_IDLE: begin
                    if (take_cmd && prn_present && cmd_code == `PPF_CMD_WRITE) begin
                        st_q <= PPF_ST_FRAME;
                    end
                end
                PPF_ST_FRAME: begin
                    if (frame_end) begin
                        st_q <= PPF_ST_DRAIN;
                    end
                end
                PPF_ST_DRAIN: begin
                    if (frame_done) begin
                        st_q <= PPF_ST_IDLE;
                    end
                end
                default: st_q <= PPF_ST_IDLE;
            endcase
        end
    end
    // Byte position and frame flags
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 6'h0;
            drop_q <= 1'b0;
            ferr_q <= 1'b0;
        end else if (st_q == PPF_ST_IDLE) begin
            cnt_q <= 6'h0;
            drop_q <= 1'b0;
            ferr_q <= 1'b0;
        end else if (take_byte) begin
            cnt_q <= cnt_q + 6'h1;
            if (is_line_end(in_byte.data)) begin
                drop_q <= 1'b1;
            end
            if (in_byte.last != (cnt_q == `PPF_FRAME_LAST)) begin
                ferr_q <= 1'b1;
            end
        end
    end
    // Line end alternation phase, carried across frames
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            eol_ph_q <= 1'b0;
        end else if (wr_en) begin
            eol_ph_q <= is_line_end(in_byte.data) && !eol_ph_q;
        end
    end
    // Frame timer, runs from write command until drained
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tmr_q <= 29'h0;
            tmo_q <= 1'b0;
        end else if (st_q == PPF_ST_IDLE) begin
            tmr_q <= 29'h0;
            tmo_q <= 1'b0;
        end else begin
            if (!tmo_q) begin
                tmr_q <= tmr_q + 29'h1;
            end
            if (tmo_hit) begin
                tmo_q <= 1'b1;
            end
        end
    end
    // Registered ready: room in buffer while a frame is open
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
            cmd_ready_q <= 1'b0;
        end else begin
            ready_q <= (st_q == PPF_ST_FRAME) && !frame_end && fcnt_d != 2'd2;
            cmd_ready_q <= (st_q == PPF_ST_IDLE) && !take_cmd;
        end
    end

    // ------------------------------------------------------------
    // Result and status reply
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            res_q <= `PPF_RES_OK;
        end else if (take_cmd && prn_present) begin
            case (cmd_code)
                `PPF_CMD_OPEN, `PPF_CMD_CLOSE: res_q <= `PPF_RES_OK;
                `PPF_CMD_WRITE, `PPF_CMD_STATUS: res_q <= res_q;
                default: res_q <= `PPF_RES_BAD_CMD;
            endcase
        end else if (frame_done) begin
            if (tmo_q) begin
                res_q <= `PPF_RES_TIMEOUT;
            end else if (ferr_q) begin
                res_q <= `PPF_RES_FRAME_ERR;
            end else begin
                res_q <= `PPF_RES_OK;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_q <= 1'b0;
            rsp_code_q <= 8'h00;
        end else begin
            rsp_valid_q <= take_cmd && cmd_code == `PPF_CMD_STATUS && prn_present && prn_power;
            if (take_cmd && cmd_code == `PPF_CMD_STATUS) begin
                rsp_code_q <= res_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Two-entry buffer
    // ------------------------------------------------------------
    always_comb begin
        fcnt_d = fcnt_q;
        if (tmo_q) begin
            fcnt_d = 2'd0;
        end else if (wr_en && !rd_en) begin
            fcnt_d = fcnt_q + 2'd1;
        end else if (rd_en && !wr_en) begin
            fcnt_d = fcnt_q - 2'd1;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            fcnt_q <= 2'd0;
        end else begin
            fcnt_q <= fcnt_d;
            if (tmo_q) begin
                rp_q <= wp_q;
            end else begin
                if (wr_en) begin
                    wp_q <= bump(wp_q);
                end
                if (rd_en) begin
                    rp_q <= bump(rp_q);
                end
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem_q[wp_q] <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // Printer handshake
    // ------------------------------------------------------------
    assign rd_en = (pst_q == PPF_PR_IDLE) && fcnt_q != 2'd0 && !prn_busy && !tmo_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pst_q <= PPF_PR_IDLE;
            stb_q <= 7'h0;
            prn_data_q <= 8'h00;
            prn_strobe_q <= 1'b0;
        end else if (tmo_q) begin
            pst_q <= PPF_PR_IDLE;
            prn_strobe_q <= 1'b0;
        end else begin
            case (pst_q)
                PPF_PR_IDLE: begin
                    if (rd_en) begin
                        prn_data_q <= mem_q[rp_q];
                        prn_strobe_q <= 1'b1;
                        stb_q <= STROBE_CYC;
                        pst_q <= PPF_PR_STROBE;
                    end
                end
                PPF_PR_STROBE: begin
                    stb_q <= stb_q - 7'h1;
                    if (stb_q == 7'h1) begin
                        prn_strobe_q <= 1'b0;
                        pst_q <= PPF_PR_WAIT;
                    end
                end
                PPF_PR_WAIT: begin
                    if (prn_ack) begin
                        pst_q <= PPF_PR_IDLE;
                    end
                end
                default: pst_q <= PPF_PR_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_NO_REPLY_ABSENT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rsp_valid |-> $past(prn_present) && $past(prn_power))
        else $error("status reply without a powered printer");
    AST_WRITE_NEEDS_PRINTER: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_q == PPF_ST_IDLE && take_cmd && !prn_present) |=> st_q == PPF_ST_IDLE)
        else $error("write accepted without a printer");
    AST_DROP_AFTER_END: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take_byte && is_line_end(in_byte.data) && st_q == PPF_ST_FRAME) |=> drop_q && !wr_en)
        else $error("character after line end forwarded");
    AST_END_TO_CR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_en && is_line_end(in_byte.data) && !eol_ph_q) |-> wr_data == `PPF_CR_CODE)
        else $error("line end not turned into carriage return");
    AST_PASS_THROUGH: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_en && !is_line_end(in_byte.data)) |-> wr_data == in_byte.data)
        else $error("ordinary byte altered");
    AST_ALTERNATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_en && wr_data == `PPF_CR_CODE && is_line_end(in_byte.data)) |=> eol_ph_q)
        else $error("line end phase not advanced");
    AST_TIMEOUT_RESULT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (frame_done && tmo_q) |=> res_q == `PPF_RES_TIMEOUT)
        else $error("timeout not reported");
    AST_REPLY_CODE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take_cmd && cmd_code == `PPF_CMD_STATUS && prn_present && prn_power)
            |=> rsp_valid && rsp_code == $past(res_q))
        else $error("status reply wrong");
    AST_RESULT_HELD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!take_cmd && !frame_done) |=> $stable(res_q))
        else $error("result changed without an operation");
    AST_FRAME_COUNT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_q == PPF_ST_FRAME) |-> cnt_q < `PPF_FRAME_LEN)
        else $error("frame longer than forty bytes");
    AST_BUF_BOUND: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fcnt_q == 2'd2 |-> !wr_en)
        else $error("buffer overrun");

endmodule

// File: ppf_printer_model.sv
// Behavioural parallel printer that answers each character after a set delay
`timescale 1ns/1ns
module ppf_printer_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] prn_data,
    input wire logic prn_strobe,
    input wire logic [9:0] ack_delay,
    output logic prn_busy,
    output logic prn_ack
);
    logic [7:0] got[$];
    logic in_char = 1'b0;
    int wait_cnt = 0;

    // --------------------------------------------
    // Take a character, acknowledge after a delay
    // --------------------------------------------
    always @(negedge clk_sys) begin
        if (!rst_n) begin
            in_char <= 1'b0;
            wait_cnt <= 0;
            prn_busy <= 1'b0;
            prn_ack <= 1'b0;
        end else if (prn_strobe && !in_char) begin
            got.push_back(prn_data);
            in_char <= 1'b1;
            wait_cnt <= 0;
            prn_busy <= 1'b1;
            prn_ack <= 1'b0;
        end else if (in_char && !prn_strobe && wait_cnt >= ack_delay) begin
            in_char <= 1'b0;
            prn_busy <= 1'b0;
            prn_ack <= 1'b1;
        end else begin
            prn_ack <= 1'b0;
            if (in_char && !prn_strobe) begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule

// File: test_printer_port_frame_forwarder.sv
// Self-checking bench for the printer port frame forwarder
`timescale 1ns/1ns
`include "ppf_map.svh"
module test_printer_port_frame_forwarder import ppf_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_code = 3'h0;
    logic in_valid = 1'b0;
    ppf_byte_t in_byte = '0;
    logic prn_present = 1'b1;
    logic prn_power = 1'b1;
    logic [9:0] ack_delay = 10'h004;
    logic cmd_ready, in_ready, rsp_valid, prn_strobe, prn_busy, prn_ack;
    logic [7:0] rsp_code, prn_data;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [7:0] frm[$];
    logic [7:0] exp_q[$];

    always #5 clk_sys = ~clk_sys;

    // --------------------
    // Design and printer
    // --------------------
    ppf_forwarder #(.TIMEOUT_CYC(29'h1770)) ppf_forwarder_inst (.clk_sys(clk_sys),
        .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready),
        .in_valid(in_valid), .in_byte(in_byte), .in_ready(in_ready), .rsp_valid(rsp_valid),
        .rsp_code(rsp_code), .prn_present(prn_present), .prn_power(prn_power),
        .prn_busy(prn_busy), .prn_ack(prn_ack), .prn_data(prn_data), .prn_strobe(prn_strobe));
    ppf_printer_model ppf_printer_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .prn_data(prn_data), .prn_strobe(prn_strobe), .ack_delay(ack_delay),
        .prn_busy(prn_busy), .prn_ack(prn_ack));

    // --------------------
    // Helpers
    // --------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Lets one edge pass with valid low, then waits out any frame in flight
    task automatic send_cmd(input logic [2:0] code);
        int n;
        n = 0;
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_code = code;
        while (cmd_ready !== 1'b1 && n < 20000) begin
            @(negedge clk_sys);
            n++;
        end
        check("cmd_ready", {7'h00, cmd_ready}, 8'h01);
        @(posedge clk_sys);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
    endtask

    task automatic query(output logic got, output logic [7:0] code);
        got = 1'b0;
        code = 8'h00;
        send_cmd(`PPF_CMD_STATUS);
        repeat (4) begin
            if (rsp_valid === 1'b1) begin
                got = 1'b1;
                code = rsp_code;
            end
            @(negedge clk_sys);
        end
    endtask

    task automatic expect_status(input logic [7:0] exp);
        logic got;
        logic [7:0] code;
        query(got, code);
        check("status reply", {7'h00, got}, 8'h01);
        check("status code", code, exp);
    endtask

    task automatic send_frame();
        int n;
        send_cmd(`PPF_CMD_WRITE);
        foreach (frm[i]) begin
            in_valid = 1'b1;
            in_byte.data = frm[i];
            in_byte.last = (i == frm.size() - 1);
            n = 0;
            while (in_ready !== 1'b1 && n < 2000) begin
                @(negedge clk_sys);
                n++;
            end
            check("in_ready", {7'h00, in_ready}, 8'h01);
            @(posedge clk_sys);
            @(negedge clk_sys);
        end
        in_valid = 1'b0;
        frm.delete();
    endtask

    task automatic pad();
        while (frm.size() < 40) frm.push_back(`PPF_BLANK_CODE);
    endtask

    task automatic check_print(input string what);
        check({what, " count"}, 8'(ppf_printer_model_inst.got.size()), 8'(exp_q.size()));
        foreach (exp_q[i]) check(what, ppf_printer_model_inst.got[i], exp_q[i]);
        ppf_printer_model_inst.got.delete();
        exp_q.delete();
    endtask

    // --------------------
    // Scenarios
    // --------------------
    task automatic t_reset();
        check("cmd_ready", {7'h00, cmd_ready}, 8'h01);
        check("in_ready", {7'h00, in_ready}, 8'h00);
        expect_status(`PPF_RES_OK);
        $display("done reset");
    endtask

    task automatic t_full();
        for (int i = 0; i < 40; i++) frm.push_back(8'(i * 37));
        exp_q = frm;
        send_frame();
        expect_status(`PPF_RES_OK);
        check_print("full frame");
        $display("done full frame");
    endtask

    task automatic t_line_end();
        for (int i = 0; i < 5; i++) frm.push_back(8'h41 + 8'(i));
        frm.push_back(8'hc1);
        exp_q = frm;
        frm.push_back(`PPF_LINE_END_CODE);
        frm.push_back(8'h55);
        pad();
        exp_q.push_back(`PPF_CR_CODE);
        send_frame();
        expect_status(`PPF_RES_OK);
        check_print("line end");
        $display("done line end");
    endtask

    task automatic t_line_run();
        exp_q = '{`PPF_BLANK_CODE, `PPF_CR_CODE, 8'h51, `PPF_CR_CODE};
        repeat (2) begin
            frm.push_back(`PPF_LINE_END_CODE);
            pad();
            send_frame();
        end
        frm = '{8'h51, `PPF_LINE_END_CODE};
        pad();
        send_frame();
        expect_status(`PPF_RES_OK);
        check_print("line end run");
        $display("done line end run");
    endtask

    task automatic t_cmds();
        for (int c = 4; c < 8; c++) begin
            send_cmd(3'(c));
            expect_status(`PPF_RES_BAD_CMD);
        end
        send_cmd(`PPF_CMD_OPEN);
        expect_status(`PPF_RES_OK);
        send_cmd(3'h4);
        send_cmd(`PPF_CMD_CLOSE);
        expect_status(`PPF_RES_OK);
        $display("done commands");
    endtask

    task automatic t_frame_err();
        for (int i = 0; i < 11; i++) frm.push_back(8'h30 + 8'(i));
        exp_q = frm;
        send_frame();
        expect_status(`PPF_RES_FRAME_ERR);
        check_print("short frame");
        $display("done frame error");
    endtask

    task automatic t_timeout();
        ack_delay = 10'h0fa;
        repeat (40) frm.push_back(8'h41);
        send_frame();
        expect_status(`PPF_RES_TIMEOUT);
        ack_delay = 10'h004;
        expect_status(`PPF_RES_TIMEOUT);
        repeat (400) @(negedge clk_sys);
        ppf_printer_model_inst.got.delete();
        $display("done timeout");
    endtask

    task automatic t_absent();
        logic got;
        logic [7:0] code;
        prn_present = 1'b0;
        send_cmd(3'h5);
        query(got, code);
        check("reply absent", {7'h00, got}, 8'h00);
        prn_present = 1'b1;
        prn_power = 1'b0;
        query(got, code);
        check("reply unpowered", {7'h00, got}, 8'h00);
        prn_power = 1'b1;
        expect_status(`PPF_RES_TIMEOUT);
        $display("done absent printer");
    endtask

    // --------------------
    // Run
    // --------------------
    initial begin
        #400_000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        t_reset();
        t_full();
        t_line_end();
        t_line_run();
        t_cmds();
        t_frame_err();
        t_timeout();
        t_absent();
        stop_test();
    end
endmodule
